//--- rtl/pfch_pkg.sv
// Purpose: shared constants for the xoff holdoff timer block
// Assumes: 32-bit ahb-lite register bus, one register per aligned word
// Notes:   register byte address is four times its index
package pfch_pkg;
    // -----------------------------------------------------------------
    // sizes
    // -----------------------------------------------------------------
    localparam int NUM_CLASS = 6;
    localparam int CLS_W = 3;
    localparam int HOLD_W = 16;
    localparam int CNT_W = 19;
    localparam int IDX_W = 12;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int REG_CODE_W = 4;
    // -----------------------------------------------------------------
    // register map (indices)
    // -----------------------------------------------------------------
    localparam logic [NUM_CLASS-1:0][IDX_W-1:0] IDX_HOLDOFF =
        {12'h62D, 12'h62C, 12'h62B, 12'h62A, 12'h629, 12'h628};
    localparam logic [NUM_CLASS-1:0][IDX_W-1:0] IDX_QUANTA =
        {12'h635, 12'h634, 12'h633, 12'h632, 12'h631, 12'h630};
    localparam logic [IDX_W-1:0] IDX_CTRL = 12'h638;
    localparam logic [IDX_W-1:0] IDX_STATUS = 12'h639;
    localparam int ADDR_IDX_LSB = 2;
    localparam int CTRL_RATE_BIT = 8;
    localparam int STATUS_RUN_LSB = 8;
    // decoded register codes: holdoff classes use 0..5
    localparam logic [REG_CODE_W-1:0] CODE_QUANTA_BASE = 4'h6;
    localparam logic [REG_CODE_W-1:0] CODE_CTRL = 4'hC;
    localparam logic [REG_CODE_W-1:0] CODE_STATUS = 4'hD;
    localparam logic [REG_CODE_W-1:0] CODE_NONE = 4'hF;
    // -----------------------------------------------------------------
    // reset values and timing
    // -----------------------------------------------------------------
    localparam logic [HOLD_W-1:0] HOLD_RESET = 16'hFFFF;
    localparam logic [HOLD_W-1:0] QUANTA_RESET = 16'hFFFF;
    localparam logic [CNT_W-1:0] TICKS_LOW_RATE = 19'h00008;
    localparam logic [CNT_W-1:0] TICKS_HIGH_RATE = 19'h00002;
    localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;
    // -----------------------------------------------------------------
    // ahb-lite codes
    // -----------------------------------------------------------------
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

//--- rtl/pfch_timer.sv
// Purpose: one class holdoff timer, counts interval units of 8 or 2 cycles
// Assumes: start is a one-cycle pulse, interval sampled at start
// Notes:   an interval of zero is timed as one unit
`timescale 1ns/1ps
module pfch_timer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic start,
    input wire logic enable,
    input wire logic rate_100g,
    input wire logic [pfch_pkg::HOLD_W-1:0] interval,
    // status
    output logic running,
    output logic expired
);
    import pfch_pkg::*;

    logic [CNT_W-1:0] cnt, next_cnt, ticks, total;
    logic next_running, next_expired;

    // -----------------------------------------------------------------
    // countdown
    // -----------------------------------------------------------------
    always_comb begin
        ticks = rate_100g ? TICKS_HIGH_RATE : TICKS_LOW_RATE; // RULE2 RULE3
        total = (interval == '0) ? ticks : CNT_W'(interval) * ticks;
        next_cnt = cnt;
        next_running = running;
        next_expired = 1'b0;
        if (start && enable) begin
            next_cnt = total;
            next_running = 1'b1;
        end else if (!enable) begin
            next_running = 1'b0;
        end else if (running) begin
            if (cnt == CNT_ONE) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end else begin
                next_cnt = cnt - CNT_ONE;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            cnt <= next_cnt;
            running <= next_running;
            expired <= next_expired;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic [CNT_W:0] elapsed;
    logic [HOLD_W-1:0] interval_q;
    logic rate_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            elapsed <= '0;
            interval_q <= '0;
            rate_q <= 1'b0;
        end else if (start && enable) begin
            elapsed <= '0;
            interval_q <= interval;
            rate_q <= rate_100g;
        end else begin
            elapsed <= elapsed + (CNT_W+1)'(1);
        end
    end

    low_rate_time_a: assert property ( // RULE2
        @(posedge hclk) disable iff (!hresetn)
        expired && !rate_q && interval_q != '0 |->
            elapsed == (CNT_W+1)'(CNT_W'(interval_q) * TICKS_LOW_RATE))
        else $error("holdoff expiry not at eight cycles per unit");
    high_rate_time_a: assert property ( // RULE3
        @(posedge hclk) disable iff (!hresetn)
        expired && rate_q && interval_q != '0 |->
            elapsed == (CNT_W+1)'(CNT_W'(interval_q) * TICKS_HIGH_RATE))
        else $error("holdoff expiry not at two cycles per unit");
endmodule

//--- rtl/pfch_holdoff.sv
// Purpose: per-class xoff holdoff timers with ahb-lite register access
// Assumes: class_paused and xoff_sent synchronous to hclk
// Notes:   zero-wait bus slave, read data taken from next-state values except the status running bits
`timescale 1ns/1ps
// Operation
// (RULE1) each class keeps a 16-bit holdoff, used only when its retransmit is on
// (RULE2) at 10G/25G one holdoff unit lasts eight clock cycles
// (RULE3) at 100G one holdoff unit lasts two clock cycles
// (RULE4) software programs a holdoff of one or more, ideally large
// (RULE5) at 10G/25G software keeps holdoff under quanta minus 60 plus frame/8
// (RULE6) at 100G software keeps holdoff under quanta minus 50 plus frame/32
// (RULE7) after power-on every holdoff register reads 16'hFFFF
// (RULE8) configuration reset reloads holdoff from pause or per-class parameters
// (RULE9) each xoff carries that class's 16-bit pause quanta
// (RULE10) sending xoff starts the timer; expiry while paused and enabled resends
module pfch_holdoff #(
    parameter logic FLOW_PFC = 1'b1,
    parameter logic [pfch_pkg::HOLD_W-1:0] HOLDOFF_PAUSE = pfch_pkg::HOLD_RESET,
    parameter logic [pfch_pkg::NUM_CLASS-1:0][pfch_pkg::HOLD_W-1:0] PFC_HOLDOFF =
        {pfch_pkg::NUM_CLASS{pfch_pkg::HOLD_RESET}}
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cfg_rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [pfch_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [pfch_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [pfch_pkg::DATA_W-1:0] hrdata,
    output logic hresp,
    // mac flow-control side
    input wire logic [pfch_pkg::NUM_CLASS-1:0] class_paused,
    input wire logic xoff_sent,
    output logic xoff_req,
    output logic [pfch_pkg::CLS_W-1:0] xoff_class,
    output logic [pfch_pkg::HOLD_W-1:0] xoff_quanta
);
    import pfch_pkg::*;

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic [NUM_CLASS-1:0][HOLD_W-1:0] holdoff, next_holdoff;
    logic [NUM_CLASS-1:0][HOLD_W-1:0] quanta, next_quanta;
    logic [NUM_CLASS-1:0] retx_en, next_retx_en;
    logic rate_100g, next_rate_100g;
    logic wr_pend, next_wr_pend;
    logic [REG_CODE_W-1:0] wr_code, next_wr_code, addr_code;
    logic [DATA_W-1:0] next_hrdata;
    logic next_hreadyout, next_hresp, addr_ok;
    logic [NUM_CLASS-1:0] pending, next_pending, paused_q, next_paused_q;
    logic [NUM_CLASS-1:0] start, expired, running;
    logic next_xoff_req, sent_ok;
    logic [CLS_W-1:0] next_xoff_class;
    logic [HOLD_W-1:0] next_xoff_quanta;

    // maps a byte address onto a register code, CODE_NONE if unmapped
    function automatic logic [REG_CODE_W-1:0] reg_code(input logic [ADDR_W-1:0] addr);
        logic [REG_CODE_W-1:0] code;
        logic [IDX_W-1:0] idx;
        code = CODE_NONE;
        idx = addr[ADDR_IDX_LSB +: IDX_W];
        if (addr[ADDR_IDX_LSB-1:0] == '0 && addr[ADDR_W-1:ADDR_IDX_LSB+IDX_W] == '0) begin
            for (int i = 0; i < NUM_CLASS; i++) begin
                if (idx == IDX_HOLDOFF[i]) begin
                    code = REG_CODE_W'(i);
                end
                if (idx == IDX_QUANTA[i]) begin
                    code = CODE_QUANTA_BASE + REG_CODE_W'(i);
                end
            end
            if (idx == IDX_CTRL) begin
                code = CODE_CTRL;
            end
            if (idx == IDX_STATUS) begin
                code = CODE_STATUS;
            end
        end
        return code;
    endfunction

    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // -----------------------------------------------------------------
    // bus slave
    // -----------------------------------------------------------------
    always_comb begin
        addr_ok = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
        addr_code = reg_code(haddr);
        next_wr_pend = addr_ok && hwrite && (hsize == HSIZE_WORD);
        next_wr_code = addr_code;
        next_hreadyout = 1'b1;
        next_hresp = HRESP_OKAY;
        next_hrdata = hrdata;
        if (addr_ok && !hwrite) begin
            // read holdoff, quanta, ctrl and pending from next-state values so a write just ahead is seen
            next_hrdata = '0;
            for (int i = 0; i < NUM_CLASS; i++) begin
                if (addr_code == REG_CODE_W'(i)) begin
                    next_hrdata[HOLD_W-1:0] = next_holdoff[i];
                end
                if (addr_code == CODE_QUANTA_BASE + REG_CODE_W'(i)) begin
                    next_hrdata[HOLD_W-1:0] = next_quanta[i];
                end
            end
            if (addr_code == CODE_CTRL) begin
                next_hrdata[NUM_CLASS-1:0] = next_retx_en;
                next_hrdata[CTRL_RATE_BIT] = next_rate_100g;
            end
            if (addr_code == CODE_STATUS) begin
                next_hrdata[NUM_CLASS-1:0] = next_pending;
                next_hrdata[STATUS_RUN_LSB +: NUM_CLASS] = running;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_code <= CODE_NONE;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            wr_pend <= next_wr_pend;
            wr_code <= next_wr_code;
            hrdata <= next_hrdata;
            hreadyout <= next_hreadyout;
            hresp <= next_hresp;
        end
    end

    bus_okay_a: assert property (hresp == HRESP_OKAY && hreadyout)
        else $error("slave answered other than okay with no wait");
    // read data stands until the next accepted read
    hrdata_hold_a: assert property (!(addr_ok && !hwrite) |=> $stable(hrdata))
        else $error("read data changed with no read accepted");

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_comb begin
        next_holdoff = holdoff;
        next_quanta = quanta;
        next_retx_en = retx_en;
        next_rate_100g = rate_100g;
        if (!cfg_rst_n) begin
            for (int i = 0; i < NUM_CLASS; i++) begin
                next_holdoff[i] = FLOW_PFC ? PFC_HOLDOFF[i] : HOLDOFF_PAUSE; // RULE8
                next_quanta[i] = QUANTA_RESET;
            end
            next_retx_en = '0;
            next_rate_100g = 1'b0;
        end else if (wr_pend) begin
            for (int i = 0; i < NUM_CLASS; i++) begin
                if (wr_code == REG_CODE_W'(i)) begin
                    next_holdoff[i] = hwdata[HOLD_W-1:0]; // RULE1
                end
                if (wr_code == CODE_QUANTA_BASE + REG_CODE_W'(i)) begin
                    next_quanta[i] = hwdata[HOLD_W-1:0]; // RULE9
                end
            end
            if (wr_code == CODE_CTRL) begin
                next_retx_en = hwdata[NUM_CLASS-1:0];
                next_rate_100g = hwdata[CTRL_RATE_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            holdoff <= {NUM_CLASS{HOLD_RESET}}; // RULE7
            quanta <= {NUM_CLASS{QUANTA_RESET}};
            retx_en <= '0;
            rate_100g <= 1'b0;
        end else begin
            holdoff <= next_holdoff;
            quanta <= next_quanta;
            retx_en <= next_retx_en;
            rate_100g <= next_rate_100g;
        end
    end

    logic seen_clk;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_clk <= 1'b0;
        end else begin
            seen_clk <= 1'b1;
        end
    end

    power_on_value_a: assert property ( // RULE7
        !seen_clk |-> holdoff == {NUM_CLASS{HOLD_RESET}})
        else $error("holdoff not all ones after power-on");
    cfg_reload_a: assert property ( // RULE8
        !cfg_rst_n |=> holdoff[0] == (FLOW_PFC ? PFC_HOLDOFF[0] : HOLDOFF_PAUSE)
            && holdoff[NUM_CLASS-1] == (FLOW_PFC ? PFC_HOLDOFF[NUM_CLASS-1] : HOLDOFF_PAUSE))
        else $error("holdoff not reloaded by configuration reset");
    write_lands_a: assert property ( // RULE1
        wr_pend && cfg_rst_n && wr_code == '0 |=> holdoff[0] == $past(hwdata[HOLD_W-1:0]))
        else $error("holdoff write did not land in the data phase");

    // -----------------------------------------------------------------
    // per-class timers
    // -----------------------------------------------------------------
    for (genvar g = 0; g < NUM_CLASS; g++) begin : gen_timer
        pfch_timer u_timer (
            .hclk(hclk),
            .hresetn(hresetn),
            .start(start[g]),
            .enable(retx_en[g]), // RULE1
            .rate_100g(rate_100g),
            .interval(holdoff[g]),
            .running(running[g]),
            .expired(expired[g])
        );
    end

    retx_off_stop_a: assert property ( // RULE1
        !retx_en[0] |=> !running[0])
        else $error("class 0 timer ran with retransmission disabled");

    // -----------------------------------------------------------------
    // xoff request scheduling
    // -----------------------------------------------------------------
    always_comb begin
        sent_ok = xoff_sent && xoff_req;
        next_paused_q = class_paused;
        for (int i = 0; i < NUM_CLASS; i++) begin
            // a new set wins over the clear of a frame just sent
            start[i] = sent_ok && xoff_class == CLS_W'(i) && retx_en[i]; // RULE10
            next_pending[i] = (class_paused[i] && !paused_q[i])
                || (expired[i] && class_paused[i] && retx_en[i]) // RULE1 RULE10
                || (pending[i] && !(sent_ok && xoff_class == CLS_W'(i)));
        end
        next_xoff_req = xoff_req;
        next_xoff_class = xoff_class;
        next_xoff_quanta = xoff_quanta;
        if (!(xoff_req && !sent_ok)) begin
            next_xoff_req = |next_pending;
            for (int i = NUM_CLASS - 1; i >= 0; i--) begin
                if (next_pending[i]) begin
                    next_xoff_class = CLS_W'(i);
                    next_xoff_quanta = next_quanta[i]; // RULE9
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            paused_q <= '0;
            pending <= '0;
            xoff_req <= 1'b0;
            xoff_class <= '0;
            xoff_quanta <= QUANTA_RESET;
        end else begin
            paused_q <= next_paused_q;
            pending <= next_pending;
            xoff_req <= next_xoff_req;
            xoff_class <= next_xoff_class;
            xoff_quanta <= next_xoff_quanta;
        end
    end

    retx_gate_a: assert property ( // RULE1
        $rose(pending[0]) |-> $past(retx_en[0]) || $rose(paused_q[0]))
        else $error("class 0 resent with retransmission disabled");
    resend_on_expiry_a: assert property ( // RULE10
        expired[0] && class_paused[0] && retx_en[0] |=> pending[0])
        else $error("expiry while paused did not queue another xoff");
    timer_restart_a: assert property ( // RULE10
        xoff_sent && xoff_req && xoff_class == '0 && retx_en[0] |=> running[0])
        else $error("holdoff timer not started after xoff sent");
    quanta_carry_a: assert property ( // RULE9
        $rose(xoff_req) |-> xoff_quanta == quanta[xoff_class])
        else $error("xoff quanta does not match its class");
    req_hold_a: assert property ( // RULE10
        xoff_req && !xoff_sent |=> xoff_req && $stable(xoff_class) && $stable(xoff_quanta))
        else $error("xoff request dropped or changed before sent");
    req_pending_a: assert property ( // RULE10
        xoff_req |-> pending[xoff_class])
        else $error("xoff request without a pending class");
    pending_hold_a: assert property ( // RULE10
        pending[0] && !(xoff_req && xoff_sent && xoff_class == '0) |=> pending[0])
        else $error("class 0 xoff dropped before it was sent");
    // the first xoff of a pause episode goes out whatever the enable
    first_xoff_a: assert property ( // RULE10
        class_paused[0] && !paused_q[0] |=> pending[0])
        else $error("rising pause did not queue an xoff");

    sent_c: cover property (xoff_sent && xoff_req && retx_en[xoff_class]);
    resend_c: cover property (expired[0] && class_paused[0] && retx_en[0]);
    fast_rate_c: cover property (rate_100g && expired[NUM_CLASS-1]);
    cfg_reset_c: cover property (!cfg_rst_n ##1 cfg_rst_n);
    status_read_c: cover property (addr_ok && !hwrite && addr_code == CODE_STATUS);
endmodule

//--- verification/pfch_holdoff_tb.sv
// Purpose: self-checking bench for the xoff holdoff timer block
// Assumes: zero-wait ahb-lite slave, hready looped back from hreadyout
// Notes:   small holdoff values keep every retransmit interval short
`timescale 1ns/1ps
module pfch_holdoff_tb;
    import pfch_pkg::*;
    // -----------------------------------------------------------------
    // parameters and signals
    // -----------------------------------------------------------------
    localparam logic [NUM_CLASS-1:0][HOLD_W-1:0] P_HOLD =
        {16'h0015, 16'h0014, 16'h0013, 16'h0012, 16'h0011, 16'h0010};
    logic hclk = 1'b0;
    logic hresetn;
    logic cfg_rst_n;
    logic hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [DATA_W-1:0] hwdata;
    logic hreadyout;
    logic [DATA_W-1:0] hrdata;
    logic hresp;
    logic [NUM_CLASS-1:0] class_paused;
    logic xoff_sent;
    logic xoff_req;
    logic [CLS_W-1:0] xoff_class;
    logic [HOLD_W-1:0] xoff_quanta;
    int mismatches = 0;
    int total_checks = 0;

    always #50 hclk = ~hclk;

    pfch_holdoff #(
        .FLOW_PFC(1'b1),
        .HOLDOFF_PAUSE(HOLD_RESET),
        .PFC_HOLDOFF(P_HOLD)
    ) i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .cfg_rst_n(cfg_rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .class_paused(class_paused),
        .xoff_sent(xoff_sent),
        .xoff_req(xoff_req),
        .xoff_class(xoff_class),
        .xoff_quanta(xoff_quanta)
    );

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [ADDR_W-1:0] addr_of(input logic [IDX_W-1:0] idx);
        return {18'h00000, idx, 2'h0};
    endfunction

    // one single ahb-lite word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        bus(1'b0, a, 32'h00000000, d);
    endtask

    // n counts settled cycles after the last edge until a request shows
    task automatic wait_req(output int n);
        for (n = 0; n < 200; n++) begin
            @(negedge hclk);
            if (xoff_req === 1'b1) break;
        end
    endtask

    task automatic send(input logic drop, input int c);
        @(posedge hclk);
        xoff_sent <= 1'b1;
        if (drop) class_paused[c] <= 1'b0;
        @(posedge hclk);
        xoff_sent <= 1'b0;
    endtask

    // -----------------------------------------------------------------
    // watchdog
    // -----------------------------------------------------------------
    initial begin
        #(100 * 20000);
        mismatches++;
        test_done();
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        logic [DATA_W-1:0] v;
        logic [DATA_W-1:0] w;
        logic [HOLD_W-1:0] q;
        logic en;
        logic rate;
        int n;
        int c;
        int h;
        int tk;
        hresetn = 1'b0;
        cfg_rst_n = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h00000000;
        class_paused = 6'h00;
        xoff_sent = 1'b0;
        void'($urandom(47732));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // power-on values and an unmapped read
        for (int i = 0; i < NUM_CLASS; i++) begin
            rd(addr_of(IDX_HOLDOFF[i]), v);
            check(v, {16'h0000, HOLD_RESET});
            rd(addr_of(IDX_QUANTA[i]), v);
            check(v, {16'h0000, QUANTA_RESET});
        end
        rd(addr_of(IDX_CTRL), v);
        check(v, 32'h00000000);
        rd(32'h00000000, v);
        check(v, 32'h00000000);
        // random holdoff writes, read back at once; only 16 bits are held
        for (int i = 0; i < 12; i++) begin
            c = $urandom % NUM_CLASS;
            v = $urandom | 32'h00000001;
            wr(addr_of(IDX_HOLDOFF[c]), v);
            rd(addr_of(IDX_HOLDOFF[c]), w);
            check(w, {16'h0000, v[15:0]});
        end
        // configuration reset reloads the per-class build values
        @(posedge hclk);
        cfg_rst_n <= 1'b0;
        @(posedge hclk);
        cfg_rst_n <= 1'b1;
        for (int i = 0; i < NUM_CLASS; i++) begin
            rd(addr_of(IDX_HOLDOFF[i]), v);
            check(v, {16'h0000, P_HOLD[i]});
        end
        // retransmit timing at both rates, with and without enable
        for (int t = 0; t < 12; t++) begin
            c = $urandom % NUM_CLASS;
            h = 1 + $urandom % 4;
            rate = 1'($urandom % 2);
            en = (t % 3) != 2;
            // quanta far above holdoff plus any overrun margin
            q = 16'h8000 | 16'($urandom);
            tk = h * int'(rate ? TICKS_HIGH_RATE : TICKS_LOW_RATE);
            wr(addr_of(IDX_HOLDOFF[c]), 32'(h));
            wr(addr_of(IDX_QUANTA[c]), {16'h0000, q});
            v = 32'h00000000;
            v[c] = en;
            v[CTRL_RATE_BIT] = rate;
            wr(addr_of(IDX_CTRL), v);
            @(posedge hclk);
            class_paused[c] <= 1'b1;
            wait_req(n);
            check({31'h0, xoff_req}, 32'h00000001);
            check({29'h0, xoff_class}, 32'(c));
            check({16'h0000, xoff_quanta}, {16'h0000, q});
            rd(addr_of(IDX_STATUS), v);
            check(v, 32'h00000001 << c);
            send(1'b0, c);
            if (en) begin
                wait_req(n);
                if (rate) check(32'(n), 32'(tk + 1));
                else check(32'(n), 32'(tk + 1));
                check({16'h0000, xoff_quanta}, {16'h0000, q});
                send(1'b1, c);
            end
            // no further request: class released, or retransmit off
            repeat (tk + 5) @(negedge hclk);
            if (en) check({31'h0, xoff_req}, 32'h00000000);
            else check({31'h0, xoff_req}, 32'h00000000);
            @(posedge hclk);
            class_paused[c] <= 1'b0;
        end
        repeat (4) @(posedge hclk);
        test_done();
    end
endmodule
